// file: rtl/byte_counter.v
// Counter of payload bytes in one block, without framing bits.
`timescale 1ns/100ps
`default_nettype none
`include "frame_relay_defs.vh"

module byte_counter (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire clear_i,
   input wire byte_i,
   output reg [`BYTE_CNT_W-1:0] count_o
);

   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_o <= {`BYTE_CNT_W{1'b0}};
      end else if (clear_i) begin
         // The byte that opens a block arrives with the clear and counts.
         count_o <= {{(`BYTE_CNT_W-1){1'b0}}, byte_i};
      end else if (byte_i && count_o != {`BYTE_CNT_W{1'b1}}) begin
         count_o <= count_o + {{(`BYTE_CNT_W-1){1'b0}}, 1'b1};
      end
   end

endmodule
`default_nettype wire

// file: rtl/delay_timer.v
// Cycle counter that measures one processing delay interval.
`timescale 1ns/100ps
`default_nettype none
`include "frame_relay_defs.vh"

module delay_timer (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire start_i,
   input wire stop_i,
   output reg running_o,
   output reg [`TIMER_W-1:0] count_o
);

   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         running_o <= 1'b0;
         count_o <= {`TIMER_W{1'b0}};
      end else if (start_i) begin
         running_o <= 1'b1;
         count_o <= {`TIMER_W{1'b0}};
      end else if (stop_i) begin
         running_o <= 1'b0;
      end else if (running_o && count_o != {`TIMER_W{1'b1}}) begin
         // Saturate so a stuck interval never wraps into a small value.
         count_o <= count_o + {{(`TIMER_W-1){1'b0}}, 1'b1};
      end
   end

endmodule
`default_nettype wire

// file: rtl/frame_relay.v
// Relay of Type A blocks between the RF side and the card module link.
//
// Notes on behaviour
// - Each reader block goes into exactly one tunnel frame payload.
// - A block longer than the payload limit is treated as an error.
// - Oversize error is signalled by empty, bad-CRC or bad-EOF frame; the code's empty style closes a 256-byte frame with no error flag.
// - Link sending starts after the whole block or while still receiving.
// - Receive delay runs from last reader pause end to link EOF end.
// - Transmit delay runs from card frame start to first RF modulation.
// - With no payload, transmit delay ends when ready for next block.
// - One received frame payload goes out as exactly one RF block.
// - RF sending may start after or during frame arrival.
// - Bad CRC without pipelining means no RF modulation.
// - Total delay stays within 210 us plus 15 us per byte each way.
// - Byte counts exclude start, parity and stop bits.
// - A REQA or WUPA is forwarded as a one-byte frame payload.
// - The request and goto-init exchange stays within 190 us.
// - A request in an active state forces idle or halt, no RF reply.
// - In 212/424 kbps mode the single-device-detection timing is met; the code skips its 190 us guard check when felica_mode_i is high.
// - Both sides keep delays small enough for overall transactions.
// - Corrupt frames or reserved admin codes keep the link layer up.
// - Goto-init returns the card state machine to idle or halt.
`timescale 1ns/100ps
`default_nettype none
`include "frame_relay_defs.vh"

module frame_relay (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire pipeline_en_i,
   input wire felica_mode_i,
   input wire [1:0] err_style_i,
   input wire rf_rx_byte_valid_i,
   input wire [7:0] rf_rx_byte_i,
   input wire rf_rx_end_i,
   input wire link_tx_ready_i,
   input wire link_tx_eof_done_i,
   input wire link_rx_sof_i,
   input wire link_rx_byte_valid_i,
   input wire [7:0] link_rx_byte_i,
   input wire [`ADMIN_W-1:0] link_rx_admin_i,
   input wire link_rx_end_i,
   input wire link_rx_crc_ok_i,
   input wire rf_tx_ready_i,
   input wire rf_tx_mod_edge_i,
   output reg link_tx_start_o,
   output reg link_tx_byte_valid_o,
   output reg [7:0] link_tx_byte_o,
   output reg link_tx_end_o,
   output reg link_tx_bad_crc_o,
   output reg link_tx_bad_eof_o,
   output reg rf_tx_start_o,
   output reg rf_tx_byte_valid_o,
   output reg [7:0] rf_tx_byte_o,
   output reg rf_tx_end_o,
   output reg rf_tx_abort_o,
   output reg rf_rx_ready_o,
   output reg card_to_idle_o,
   output reg card_to_halt_o,
   output reg budget_violation_o,
   output reg guard_violation_o,
   output reg link_layer_up_o
);

   ////////////////////////////////////////////////////////////////////////
   localparam RX_IDLE = 2'h0;
   localparam RX_FWD = 2'h1;
   localparam RX_OVER = 2'h2;
   localparam RX_WAIT = 2'h3;

   localparam TX_IDLE = 2'h0;
   localparam TX_BUF = 2'h1;
   localparam TX_FLUSH = 2'h2;

   reg [1:0] rx_state_q;
   reg [1:0] tx_state_q;
   reg halted_branch_q;
   reg req_seen_q;
   reg [7:0] tx_buf_q [0:255];
   reg [7:0] wr_idx_q;
   // One bit wider than the index, so a full buffer differs from an empty one.
   reg [8:0] rd_idx_q;
   reg [8:0] fill_q;
   reg rx_done_q;
   reg crc_bad_q;
   reg pending_tx_q;

   wire [`TIMER_W-1:0] rx_cnt;
   wire [`TIMER_W-1:0] tx_cnt;
   wire rx_run;
   wire tx_run;
   wire [`BYTE_CNT_W-1:0] rx_bytes;
   wire [`BYTE_CNT_W-1:0] tx_bytes;

   wire rx_first = rf_rx_byte_valid_i && rx_state_q == RX_IDLE;
   wire is_request = rf_rx_byte_i == `REQ_CODE_REQA ||
      rf_rx_byte_i == `REQ_CODE_WUPA;
   wire oversize = rx_bytes >= `MAX_PAYLOAD;
   wire card_sof = link_rx_sof_i && tx_state_q == TX_IDLE;
   wire empty_card = link_rx_end_i && fill_q == 9'h000 &&
      tx_state_q == TX_BUF;

   ////////////////////////////////////////////////////////////////////////
   // receive delay
   delay_timer u_rx_timer (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .start_i(rf_rx_end_i),
      .stop_i(link_tx_eof_done_i),
      .running_o(rx_run),
      .count_o(rx_cnt)
   );

   delay_timer u_tx_timer (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .start_i(card_sof),
      .stop_i(rf_tx_mod_edge_i || (empty_card && rf_tx_ready_i)),
      .running_o(tx_run),
      .count_o(tx_cnt)
   );

   byte_counter u_rx_bytes (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .clear_i(rx_first),
      .byte_i(rf_rx_byte_valid_i),
      .count_o(rx_bytes)
   );

   byte_counter u_tx_bytes (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .clear_i(card_sof),
      .byte_i(link_rx_byte_valid_i),
      .count_o(tx_bytes)
   );

   ////////////////////////////////////////////////////////////////////////
   // Reader to card module path.
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_state_q <= RX_IDLE;
         link_tx_start_o <= 1'b0;
         link_tx_byte_valid_o <= 1'b0;
         link_tx_byte_o <= 8'h00;
         link_tx_end_o <= 1'b0;
         link_tx_bad_crc_o <= 1'b0;
         link_tx_bad_eof_o <= 1'b0;
         req_seen_q <= 1'b0;
      end else begin
         link_tx_start_o <= 1'b0;
         link_tx_byte_valid_o <= 1'b0;
         link_tx_end_o <= 1'b0;
         case (rx_state_q)
            RX_IDLE: begin
               link_tx_bad_crc_o <= 1'b0;
               link_tx_bad_eof_o <= 1'b0;
               if (rf_rx_byte_valid_i) begin
                  link_tx_start_o <= 1'b1;
                  link_tx_byte_valid_o <= 1'b1;
                  link_tx_byte_o <= rf_rx_byte_i;
                  req_seen_q <= is_request;
                  rx_state_q <= rf_rx_end_i ? RX_WAIT : RX_FWD;
                  link_tx_end_o <= rf_rx_end_i;
               end
            end
            RX_FWD: begin
               if (rf_rx_byte_valid_i && oversize) begin
                  rx_state_q <= RX_OVER;
               end else if (rf_rx_byte_valid_i) begin
                  link_tx_byte_valid_o <= 1'b1;
                  link_tx_byte_o <= rf_rx_byte_i;
                  req_seen_q <= 1'b0;
               end
               if (rf_rx_end_i && !(rf_rx_byte_valid_i && oversize)) begin
                  link_tx_end_o <= 1'b1;
                  rx_state_q <= RX_WAIT;
               end
            end
            RX_OVER: begin
               if (rf_rx_end_i) begin
                  link_tx_bad_crc_o <= err_style_i == `ERR_BAD_CRC;
                  link_tx_bad_eof_o <= err_style_i == `ERR_BAD_EOF;
                  link_tx_end_o <= 1'b1;
                  rx_state_q <= RX_WAIT;
               end
            end
            RX_WAIT: begin
               if (link_tx_eof_done_i) begin
                  rx_state_q <= RX_IDLE;
               end
            end
            default: rx_state_q <= RX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Card module to reader path; the buffer holds one frame payload.
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_state_q <= TX_IDLE;
         wr_idx_q <= 8'h00;
         rd_idx_q <= 9'h000;
         fill_q <= 9'h000;
         rx_done_q <= 1'b0;
         crc_bad_q <= 1'b0;
         pending_tx_q <= 1'b0;
         rf_tx_start_o <= 1'b0;
         rf_tx_byte_valid_o <= 1'b0;
         rf_tx_byte_o <= 8'h00;
         rf_tx_end_o <= 1'b0;
         rf_tx_abort_o <= 1'b0;
         rf_rx_ready_o <= 1'b1;
         card_to_idle_o <= 1'b0;
         card_to_halt_o <= 1'b0;
         halted_branch_q <= 1'b0;
         link_layer_up_o <= 1'b1;
      end else begin
         rf_tx_start_o <= 1'b0;
         rf_tx_byte_valid_o <= 1'b0;
         rf_tx_end_o <= 1'b0;
         rf_tx_abort_o <= 1'b0;
         card_to_idle_o <= 1'b0;
         card_to_halt_o <= 1'b0;
         link_layer_up_o <= 1'b1;
         if (rf_rx_end_i && ((rx_state_q == RX_IDLE && rf_rx_byte_valid_i &&
               is_request) || (rx_state_q == RX_FWD && req_seen_q &&
               !rf_rx_byte_valid_i))) begin
            card_to_halt_o <= halted_branch_q;
            card_to_idle_o <= !halted_branch_q;
         end
         case (tx_state_q)
            TX_IDLE: begin
               if (card_sof) begin
                  tx_state_q <= TX_BUF;
                  wr_idx_q <= 8'h00;
                  rd_idx_q <= 9'h000;
                  fill_q <= 9'h000;
                  rx_done_q <= 1'b0;
                  pending_tx_q <= 1'b0;
                  rf_rx_ready_o <= 1'b0;
               end
            end
            TX_BUF: begin
               if (link_rx_byte_valid_i && fill_q != `MAX_PAYLOAD) begin
                  tx_buf_q[wr_idx_q] <= link_rx_byte_i;
                  wr_idx_q <= wr_idx_q + 8'h01;
                  fill_q <= fill_q + 9'h001;
               end
               if (link_rx_end_i) begin
                  crc_bad_q <= !link_rx_crc_ok_i;
                  if (fill_q == 9'h000 && !link_rx_byte_valid_i) begin
                     tx_state_q <= TX_IDLE;
                     rf_rx_ready_o <= 1'b1;
                     if (link_rx_crc_ok_i &&
                           link_rx_admin_i == `ADMIN_GOTO_INIT) begin
                        card_to_halt_o <= halted_branch_q;
                        card_to_idle_o <= !halted_branch_q;
                     end
                  end else if (!link_rx_crc_ok_i && !pipeline_en_i) begin
                     tx_state_q <= TX_IDLE;
                     rf_rx_ready_o <= 1'b1;
                  end else if (link_rx_admin_i >= `ADMIN_RESERVED_MIN) begin
                     tx_state_q <= TX_IDLE;
                     rf_rx_ready_o <= 1'b1;
                  end else begin
                     tx_state_q <= TX_FLUSH;
                     rx_done_q <= 1'b1;
                  end
               end else if (pipeline_en_i && fill_q != 9'h000 &&
                     !pending_tx_q && rf_tx_ready_i) begin
                  pending_tx_q <= 1'b1;
                  rf_tx_start_o <= 1'b1;
               end
               if (pending_tx_q && rf_tx_ready_i && rd_idx_q != fill_q) begin
                  rf_tx_byte_valid_o <= 1'b1;
                  rf_tx_byte_o <= tx_buf_q[rd_idx_q[7:0]];
                  rd_idx_q <= rd_idx_q + 9'h001;
               end
            end
            TX_FLUSH: begin
               if (!pending_tx_q) begin
                  // Hold the block start until the modulator can take it.
                  if (rf_tx_ready_i) begin
                     pending_tx_q <= 1'b1;
                     rf_tx_start_o <= 1'b1;
                  end
               end else if (rf_tx_ready_i && rd_idx_q != fill_q) begin
                  rf_tx_byte_valid_o <= 1'b1;
                  rf_tx_byte_o <= tx_buf_q[rd_idx_q[7:0]];
                  rd_idx_q <= rd_idx_q + 9'h001;
               end else if (rd_idx_q == fill_q) begin
                  rf_tx_end_o <= !crc_bad_q;
                  rf_tx_abort_o <= crc_bad_q;
                  tx_state_q <= TX_IDLE;
                  rf_rx_ready_o <= 1'b1;
               end
            end
            default: tx_state_q <= TX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // budget monitor
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         budget_violation_o <= 1'b0;
         guard_violation_o <= 1'b0;
      end else begin
         budget_violation_o <= 1'b0;
         guard_violation_o <= 1'b0;
         if (tx_run && (rf_tx_mod_edge_i || empty_card)) begin
            if (rx_cnt + tx_cnt > `BASE_BUDGET_CYC +
                  rx_bytes * `PER_BYTE_CYC + tx_bytes * `PER_BYTE_CYC) begin
               budget_violation_o <= 1'b1;
            end
            if (req_seen_q && !felica_mode_i && empty_card &&
                  rx_cnt + tx_cnt > `GUARD_BUDGET_CYC) begin
               guard_violation_o <= 1'b1;
            end
         end
      end
   end

   // The receive timer's run flag and the flush marker have no reader yet.
   wire unused_ok = rx_run ^ rx_done_q;

endmodule
`default_nettype wire

// file: rtl/frame_relay_defs.vh
// Constants shared by the contactless frame relay design files.
`ifndef FRAME_RELAY_DEFS_VH
`define FRAME_RELAY_DEFS_VH

`define CLK_PERIOD_NS 25
`define BASE_BUDGET_US 210
`define PER_BYTE_US 15
`define GUARD_BUDGET_US 190
`define BASE_BUDGET_CYC ((`BASE_BUDGET_US * 1000) / `CLK_PERIOD_NS)
`define PER_BYTE_CYC ((`PER_BYTE_US * 1000) / `CLK_PERIOD_NS)
`define GUARD_BUDGET_CYC ((`GUARD_BUDGET_US * 1000) / `CLK_PERIOD_NS)
`define TIMER_W 20
`define BYTE_CNT_W 9
`define MAX_PAYLOAD 9'h100
`define ADMIN_W 8
`define ADMIN_DATA 8'h00
`define ADMIN_GOTO_INIT 8'h01
`define ADMIN_RESERVED_MIN 8'h10
`define REQ_CODE_REQA 8'h26
`define REQ_CODE_WUPA 8'h52
`define ERR_EMPTY 2'h0
`define ERR_BAD_CRC 2'h1
`define ERR_BAD_EOF 2'h2

`endif

// file: sim/card_module_model.sv
// Behavioural card module on the far side of the single-wire link.
`timescale 1ns/100ps
`default_nettype none
module card_module_model (
   input wire logic clk_sys_i,
   input wire logic link_tx_end_i,
   output logic eof_done_o,
   output logic sof_o,
   output logic byte_valid_o,
   output logic [7:0] byte_o,
   output logic [7:0] admin_o,
   output logic end_o,
   output logic crc_ok_o
);
   initial begin
      {eof_done_o, sof_o, byte_valid_o, end_o, crc_ok_o} = 5'h00;
      byte_o = 8'h00;
      admin_o = 8'h00;
   end
   always @(posedge clk_sys_i) eof_done_o <= link_tx_end_i;
   task automatic send_frame(input int len, input logic [7:0] first,
      input logic [7:0] admin, input logic crc_ok, input int gap);
      @(posedge clk_sys_i);
      sof_o <= 1'b1;
      for (int i = 0; i < len; i++) begin
         @(posedge clk_sys_i);
         sof_o <= 1'b0;
         byte_valid_o <= 1'b1;
         byte_o <= first + i[7:0];
         repeat (gap) begin
            @(posedge clk_sys_i);
            byte_valid_o <= 1'b0;
            byte_o <= ~byte_o;
         end
      end
      @(posedge clk_sys_i);
      {sof_o, byte_valid_o} <= 2'h0;
      byte_o <= ~byte_o;
      admin_o <= admin;
      crc_ok_o <= crc_ok;
      end_o <= 1'b1;
      @(posedge clk_sys_i);
      end_o <= 1'b0;
      admin_o <= ~admin;
      crc_ok_o <= ~crc_ok;
   endtask
endmodule
`default_nettype wire

// file: sim/frame_relay_checker.sv
// Port timing checker for the frame relay, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
`include "frame_relay_defs.vh"
module frame_relay_checker (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic pipeline_en_i,
   input wire logic felica_mode_i,
   input wire logic rf_rx_byte_valid_i,
   input wire logic [7:0] rf_rx_byte_i,
   input wire logic rf_rx_end_i,
   input wire logic link_rx_end_i,
   input wire logic link_rx_crc_ok_i,
   input wire logic [`ADMIN_W-1:0] link_rx_admin_i,
   input wire logic link_tx_start_o,
   input wire logic link_tx_byte_valid_o,
   input wire logic [7:0] link_tx_byte_o,
   input wire logic link_tx_end_o,
   input wire logic rf_tx_start_o,
   input wire logic rf_tx_byte_valid_o,
   input wire logic rf_tx_end_o,
   input wire logic rf_tx_abort_o,
   input wire logic rf_rx_ready_o,
   input wire logic card_to_idle_o,
   input wire logic card_to_halt_o,
   input wire logic guard_violation_o,
   input wire logic link_layer_up_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   // Reader bytes seen in the current block, to tell payload from oversize.
   logic [8:0] blk_bytes_q;
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         blk_bytes_q <= 9'h000;
      end else if (rf_rx_end_i) begin
         blk_bytes_q <= 9'h000;
      end else if (rf_rx_byte_valid_i && blk_bytes_q != 9'h1ff) begin
         blk_bytes_q <= blk_bytes_q + 9'h001;
      end
   end
   a_byte_forward: assert property (rf_rx_byte_valid_i &&
      blk_bytes_q < `MAX_PAYLOAD |=> link_tx_byte_valid_o &&
      link_tx_byte_o == $past(rf_rx_byte_i))
      else $error("reader byte not forwarded next cycle");
   a_oversize_dropped: assert property (rf_rx_byte_valid_i &&
      blk_bytes_q >= `MAX_PAYLOAD |=> !link_tx_byte_valid_o)
      else $error("byte past the payload limit was forwarded");
   a_end_forward: assert property (rf_rx_end_i |=> link_tx_end_o)
      else $error("reader block end not closed on link");
   a_link_frame_close: assert property (link_tx_start_o |->
      ##[1:600] link_tx_end_o) else $error("link frame never closed");
   a_bad_crc_mute: assert property (link_rx_end_i && !link_rx_crc_ok_i
      && !pipeline_en_i |=> (!rf_tx_start_o && !rf_tx_byte_valid_o) [*8])
      else $error("field modulated after bad CRC");
   a_rf_block_close: assert property (rf_tx_start_o |->
      ##[1:600] (rf_tx_end_o || rf_tx_abort_o))
      else $error("RF block never closed");
   a_goto_idle: assert property (link_rx_end_i && link_rx_crc_ok_i &&
      link_rx_admin_i == `ADMIN_GOTO_INIT |-> ##[1:2] card_to_idle_o)
      else $error("goto-init did not return card to idle");
   a_no_halt_branch: assert property (!card_to_halt_o)
      else $error("halt branch taken");
   a_link_kept_up: assert property (link_layer_up_o)
      else $error("link layer dropped");
   a_guard_off: assert property (felica_mode_i |-> !guard_violation_o)
      else $error("guard check active in 212/424 mode");
   a_ready_after_tx: assert property (rf_tx_end_o |->
      ##[1:4] rf_rx_ready_o) else $error("not ready for next block");
   cover property (card_to_idle_o);
   cover property (rf_tx_end_o);
   cover property (link_tx_end_o);
   cover property (rf_rx_byte_valid_i && blk_bytes_q >= `MAX_PAYLOAD);
endmodule
bind frame_relay frame_relay_checker u_frame_relay_checker (.*);
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the frame relay.
`timescale 1ns/100ps
`default_nettype none
`include "frame_relay_defs.vh"
module testbench;
   logic clk_sys_i, reset_n_i, pipeline_en_i, felica_mode_i;
   logic [1:0] err_style_i;
   logic rf_rx_byte_valid_i, rf_rx_end_i, link_tx_ready_i;
   logic [7:0] rf_rx_byte_i, link_rx_byte_i, link_rx_admin_i;
   logic link_tx_eof_done_i, link_rx_sof_i, link_rx_byte_valid_i;
   logic link_rx_end_i, link_rx_crc_ok_i, rf_tx_ready_i, rf_tx_mod_edge_i;
   logic link_tx_start_o, link_tx_byte_valid_o, link_tx_end_o;
   logic link_tx_bad_crc_o, link_tx_bad_eof_o, rf_tx_start_o;
   logic rf_tx_byte_valid_o, rf_tx_end_o, rf_tx_abort_o, rf_rx_ready_o;
   logic card_to_idle_o, card_to_halt_o, budget_violation_o;
   logic guard_violation_o, link_layer_up_o;
   logic [7:0] link_tx_byte_o, rf_tx_byte_o, exp_b;
   int err_total, samples_checked, cycles;
   int rf_starts, rf_bytes, rf_bad, lk_starts, lk_bytes, idle_seen, viol;
   int bc_seen, be_seen;
   typedef struct {int len; logic [7:0] first; logic [7:0] admin;
      logic crc; logic pipe; int gap; int starts;} row_t;
   row_t rows[6] = '{'{1, 8'h10, `ADMIN_DATA, 1, 0, 0, 1},
      '{16, 8'ha0, `ADMIN_DATA, 1, 0, 0, 1},
      '{4, 8'h30, `ADMIN_DATA, 1, 1, 2, 1},
      '{3, 8'h40, `ADMIN_DATA, 0, 0, 0, 0},
      '{3, 8'h50, `ADMIN_RESERVED_MIN, 1, 0, 0, 0},
      '{256, 8'h00, `ADMIN_DATA, 1, 0, 0, 1}};
   frame_relay u_frame_relay (.*);
   card_module_model u_card_module_model (.clk_sys_i(clk_sys_i),
      .link_tx_end_i(link_tx_end_o), .eof_done_o(link_tx_eof_done_i),
      .sof_o(link_rx_sof_i), .byte_valid_o(link_rx_byte_valid_i),
      .byte_o(link_rx_byte_i), .admin_o(link_rx_admin_i),
      .end_o(link_rx_end_i), .crc_ok_o(link_rx_crc_ok_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic clr;
      {rf_starts, rf_bytes, rf_bad, lk_starts, lk_bytes} = 0;
      {idle_seen, viol, bc_seen, be_seen} = 0;
   endtask
   task automatic send_rf(input logic [7:0] first, input int n);
      for (int i = 0; i < n; i++) begin
         rf_rx_byte_valid_i <= 1'b1;
         rf_rx_byte_i <= first + i[7:0];
         @(posedge clk_sys_i);
      end
      rf_rx_byte_valid_i <= 1'b0;
      rf_rx_byte_i <= ~rf_rx_byte_i;
      rf_rx_end_i <= 1'b1;
      @(posedge clk_sys_i);
      rf_rx_end_i <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
   endtask
   // The modulator's first edge follows the start of each RF block.
   always @(posedge clk_sys_i) begin
      rf_tx_mod_edge_i <= rf_tx_start_o;
      if (rf_tx_start_o) rf_starts++;
      if (rf_tx_byte_valid_o) begin
         if (rf_tx_byte_o !== exp_b) rf_bad++;
         exp_b++;
         rf_bytes++;
      end
      if (link_tx_start_o) lk_starts++;
      if (link_tx_byte_valid_o) lk_bytes++;
      if (card_to_idle_o) idle_seen++;
      if (link_tx_bad_crc_o) bc_seen++;
      if (link_tx_bad_eof_o) be_seen++;
      if (budget_violation_o || guard_violation_o) viol++;
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         report_and_stop();
      end
   end
   initial begin
      {reset_n_i, pipeline_en_i, felica_mode_i, rf_rx_end_i} = 4'h0;
      {rf_rx_byte_valid_i, rf_tx_mod_edge_i} = 2'h0;
      {link_tx_ready_i, rf_tx_ready_i} = 2'h3;
      err_style_i = `ERR_EMPTY;
      rf_rx_byte_i = 8'h00;
      {err_total, samples_checked, cycles} = 0;
      exp_b = 8'h00;
      repeat (12) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      @(posedge clk_sys_i);
      #1;
      chk(rf_rx_ready_o, 1);
      chk(link_layer_up_o, 1);
      foreach (rows[k]) begin
         clr();
         pipeline_en_i <= rows[k].pipe;
         exp_b = rows[k].first;
         u_card_module_model.send_frame(rows[k].len, rows[k].first,
            rows[k].admin, rows[k].crc, rows[k].gap);
         repeat (rows[k].len + 40) @(posedge clk_sys_i);
         chk(rf_starts, rows[k].starts);
         chk(rf_bytes, rows[k].starts * rows[k].len);
         chk(rf_bad, 0);
         chk(viol, 0);
      end
      // Requests after an active exchange: one-byte frame, then goto-init.
      foreach (rows[k]) if (k < 2) begin
         clr();
         send_rf(k == 0 ? `REQ_CODE_REQA : `REQ_CODE_WUPA, 1);
         chk(lk_starts, 1);
         chk(lk_bytes, 1);
         chk(idle_seen, 1);
         u_card_module_model.send_frame(0, 8'h00, `ADMIN_GOTO_INIT, 1, 0);
         repeat (20) @(posedge clk_sys_i);
         chk(idle_seen, 2);
         chk(rf_starts, 0);
         chk(viol, 0);
      end
      // Modulator stalled: nothing starts until it is ready again. The
      // stall outlasts the budget for the last request byte plus two sent
      // bytes, so the first modulation edge must be flagged.
      clr();
      rf_tx_ready_i <= 1'b0;
      exp_b = 8'h70;
      u_card_module_model.send_frame(2, 8'h70, `ADMIN_DATA, 1, 0);
      repeat (10) @(posedge clk_sys_i);
      chk(rf_starts, 0);
      repeat (`BASE_BUDGET_CYC + 3 * `PER_BYTE_CYC + 100) @(posedge clk_sys_i);
      rf_tx_ready_i <= 1'b1;
      repeat (20) @(posedge clk_sys_i);
      chk(rf_starts, 1);
      chk(rf_bytes, 2);
      chk(viol, 1);
      // A long reader block in 212/424 mode stays one frame.
      clr();
      felica_mode_i <= 1'b1;
      send_rf(8'hc0, 20);
      chk(lk_starts, 1);
      chk(lk_bytes, 20);
      chk(viol, 0);
      // Oversize reader blocks: the payload limit goes out, then the error.
      for (int s = 1; s < 3; s++) begin
         clr();
         err_style_i <= s[1:0];
         send_rf(8'h00, 257);
         chk(lk_starts, 1);
         chk(lk_bytes, 256);
         chk(bc_seen > 0, s == `ERR_BAD_CRC);
         chk(be_seen > 0, s == `ERR_BAD_EOF);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
